/* File: hdl/sdbc_consts.svh */
// Address map, field positions, reset values and timing counts.
`ifndef SDBC_CONSTS_SVH
`define SDBC_CONSTS_SVH
`define SDBC_ADDR_REG_ADDR 32'h1714_0000
`define SDBC_BUF_BASE 32'h1718_0000
`define SDBC_BUF_LAST 32'h1719_FFFF
`define SDBC_WIN_BASE 32'h1710_0000
`define SDBC_WIN_LAST 32'h1710_003C
`define SDBC_DIR_BIT 31
`define SDBC_HW_HI 16
`define SDBC_HW_LO 1
`define SDBC_DIR_RESET 1'b0
`define SDBC_HW_RESET 16'h0000
`define SDBC_SYS_MHZ 200
`define SDBC_SCSI_MHZ 25
`define SDBC_SCSI_HALF_CYC (`SDBC_SYS_MHZ / (2 * `SDBC_SCSI_MHZ))
`define SDBC_STROBE_NS 80
`define SDBC_STROBE_CYC ((`SDBC_STROBE_NS * `SDBC_SYS_MHZ + 999) / 1000)
`endif

/* File: hdl/sdbc_pkg.sv */
// Types shared by the staging buffer controller.
package sdbc_pkg;
  typedef enum logic [1:0] {
    SDBC_IDLE = 2'b00,
    SDBC_REG = 2'b01,
    SDBC_XFER = 2'b10,
    SDBC_DROP = 2'b11
  } sdbc_state_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } sdbc_pio_req_t;
endpackage : sdbc_pkg

/* File: hdl/sdbc_skid.sv */
// Two-entry buffer with valid and ready on both sides and a flush.
`timescale 1ns/1ps
module sdbc_skid #(
  parameter int W = 16
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_reg [2];
  logic wp_reg;
  logic rp_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  if (W < 1) begin : g_chk
    $error("sdbc_skid: width must be at least one");
  end

  // Full and empty follow the occupancy count directly.
  assign in_ready_o = (cnt_reg != 2'd2);
  assign out_valid_o = (cnt_reg != 2'd0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_reg[rp_reg];

  // Entry storage is written only on a push.
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  // Pointers and count; a flush empties the buffer.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'd0;
    end else if (flush_i) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      if (push) begin
        wp_reg <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 2'd1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 2'd1;
      end
    end
  end
endmodule : sdbc_skid

/* File: hdl/sdbc_top.sv */
// Staging buffer, address register and DMA sequencing for the SCSI port.
`timescale 1ns/1ps
`include "sdbc_consts.svh"

// Behaviour
// - Buffer is 32K words of 32 bits, reachable from processor and DMA.
// - DMA side moves 16-bit halfwords only, over a 16-bit data path.
// - Processor reads whole words; processor writes honour each byte lane.
// - DMA requests are served while processor still reaches controller registers.
// - Address register is write-only at its address; unused bits ignored.
// - Bit 31 set moves data out of buffer; clear moves data in.
// - Bits 16 to 1 give start halfword; transfers then go upward.
// - Buffer holds 128 Kbytes across one contiguous processor address range.
// - Once started, DMA runs without processor help until it ends.
// - Controller registers sit one per word, data on low 16 bits.
// - Controller interface clock runs at 25 MHz.
module sdbc_top
  import sdbc_pkg::*;
#(
  parameter int STROBE_CYC = `SDBC_STROBE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire sdbc_pio_req_t pio_req_i,
  output logic pio_ack_o,
  output logic [31:0] pio_rdata_o,
  output logic scsi_clk_o,
  input wire logic dreq_i,
  output logic dack_n_o,
  output logic reg_cs_n_o,
  output logic reg_rd_n_o,
  output logic reg_wr_n_o,
  output logic [3:0] reg_addr_o,
  input wire logic [15:0] sd_i,
  output logic [15:0] sd_o,
  output logic sd_oe_n_o,
  output logic dma_busy_o
);
  localparam int WORDS = 32768;

  if (STROBE_CYC < 2 || STROBE_CYC > 255) begin : g_chk
    $error("sdbc_top: strobe length must lie in 2..255 cycles");
  end

  // Halfword h sits in word h[15:1]; h[0] picks the upper half.
  function automatic logic [15:0] half_of(input logic [31:0] w,
                                          input logic upper);
    half_of = upper ? w[31:16] : w[15:0];
  endfunction : half_of

  logic [31:0] mem [WORDS];
  logic dreq_m_reg;
  logic dreq_s_reg;
  logic [15:0] sd_m_reg;
  logic [15:0] sd_s_reg;
  logic dir_reg;
  logic [15:0] ptr_reg;
  sdbc_state_t st_reg;
  logic [7:0] cnt_reg;
  logic [7:0] div_reg;
  logic scsi_clk_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] sd_out_reg;
  logic sd_oe_n_reg;
  logic hit_ar;
  logic hit_buf;
  logic hit_win;
  logic fast_take;
  logic ar_wr;
  logic buf_wr;
  logic xfer_end;
  logic dma_go;
  logic reg_go;
  logic in_valid;
  logic in_ready;
  logic [15:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [15:0] out_data;
  logic dma_wr;

  // Address decode of the processor bus.
  assign hit_ar = pio_req_i.addr[31:2] == 30'(`SDBC_ADDR_REG_ADDR >> 2);
  assign hit_buf = pio_req_i.addr[31:17] == 15'(`SDBC_BUF_BASE >> 17);
  assign hit_win = (pio_req_i.addr[31:6] == 26'(`SDBC_WIN_BASE >> 6));
  assign fast_take = pio_req_i.sel & ~ack_reg & ~hit_win;
  assign ar_wr = fast_take & pio_req_i.wr & hit_ar;
  assign buf_wr = fast_take & pio_req_i.wr & hit_buf;
  assign xfer_end = (st_reg == SDBC_XFER) && (cnt_reg == 8'd1);
  // One decision for the sequencer and the pin drivers, so they never split.
  assign dma_go = dreq_s_reg && (dir_reg ? out_valid : in_ready);
  assign reg_go = pio_req_i.sel & hit_win & ~ack_reg;

  // Pins from the controller pass two flip-flops before use.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dreq_m_reg <= 1'b0;
      dreq_s_reg <= 1'b0;
      sd_m_reg <= 16'h0000;
      sd_s_reg <= 16'h0000;
    end else begin
      dreq_m_reg <= dreq_i;
      dreq_s_reg <= dreq_m_reg;
      sd_m_reg <= sd_i;
      sd_s_reg <= sd_m_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_reg <= 8'h00;
      scsi_clk_reg <= 1'b0;
    end else if (div_reg == 8'(`SDBC_SCSI_HALF_CYC - 1)) begin
      div_reg <= 8'h00;
      scsi_clk_reg <= ~scsi_clk_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // write-only register; bit 31 lands here, bits 16:1 in the pointer.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_reg <= `SDBC_DIR_RESET;
    end else if (ar_wr) begin
      dir_reg <= pio_req_i.wdata[`SDBC_DIR_BIT];
    end
  end

  // Halfword pointer: outward it runs up to two halfwords ahead of the
  // strobes to fill the buffer, inward it steps as each halfword lands.
  // counter reload
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_reg <= `SDBC_HW_RESET;
    end else if (ar_wr) begin
      ptr_reg <= pio_req_i.wdata[`SDBC_HW_HI:`SDBC_HW_LO];
    end else if ((in_valid && in_ready && dir_reg) || dma_wr) begin
      ptr_reg <= ptr_reg + 16'h0001;
    end
  end

  // outward: the buffer prefetches halfwords; inward: strobe samples.
  assign in_valid = dir_reg ? 1'b1 : (xfer_end & ~ar_wr);
  assign in_data = dir_reg ? half_of(mem[ptr_reg[15:1]], ptr_reg[0])
                           : sd_s_reg;
  // A processor buffer write in the same cycle stalls the inward drain.
  assign out_ready = dir_reg ? xfer_end : ~buf_wr;
  assign dma_wr = out_valid & out_ready & ~dir_reg & ~ar_wr;

  sdbc_skid #(
    .W(16)
  ) u_skid (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(ar_wr),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .in_data_i(in_data),
    .out_valid_o(out_valid),
    .out_ready_i(out_ready),
    .out_data_o(out_data)
  );

  always_ff @(posedge sys_clk_i) begin
    // halfword writes from the DMA side
    if (dma_wr) begin
      if (ptr_reg[0]) begin
        mem[ptr_reg[15:1]][31:16] <= out_data;
      end else begin
        mem[ptr_reg[15:1]][15:0] <= out_data;
      end
    end
    if (buf_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (pio_req_i.be[b]) begin
          mem[pio_req_i.addr[16:2]][8*b +: 8] <= pio_req_i.wdata[8*b +: 8];
        end
      end
    end
  end

  // sequencer: DMA first, register window when no DMA cycle waits.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= SDBC_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      case (st_reg)
        SDBC_IDLE: begin
          if (dma_go) begin
            st_reg <= SDBC_XFER;
            cnt_reg <= 8'(STROBE_CYC);
          end else if (reg_go) begin
            st_reg <= SDBC_REG;
            cnt_reg <= 8'(STROBE_CYC);
          end
        end
        SDBC_REG, SDBC_XFER: begin
          if (cnt_reg == 8'd1) begin
            st_reg <= (st_reg == SDBC_XFER) ? SDBC_DROP : SDBC_IDLE;
          end
          cnt_reg <= cnt_reg - 8'd1;
        end
        SDBC_DROP: begin
          if (!dreq_s_reg) begin
            st_reg <= SDBC_IDLE;
          end
        end
        default: begin
          st_reg <= SDBC_IDLE;
        end
      endcase
    end
  end

  // Strobes and shared data pins follow the sequencer state.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sd_out_reg <= 16'h0000;
      sd_oe_n_reg <= 1'b1;
    end else if (st_reg == SDBC_IDLE && dma_go && dir_reg) begin
      sd_out_reg <= out_data;
      sd_oe_n_reg <= 1'b0;
    end else if (st_reg == SDBC_IDLE && !dma_go && reg_go
                 && pio_req_i.wr) begin
      // register data on the low half only
      sd_out_reg <= pio_req_i.wdata[15:0];
      sd_oe_n_reg <= 1'b0;
    end else if (cnt_reg == 8'd1 || st_reg == SDBC_DROP) begin
      sd_oe_n_reg <= 1'b1;
    end
  end

  // Processor answers: one-cycle acknowledge with registered read data.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (fast_take) begin
      ack_reg <= 1'b1;
      // word reads; address register and holes read zero
      rdata_reg <= hit_buf ? mem[pio_req_i.addr[16:2]] : 32'h0000_0000;
    end else if (st_reg == SDBC_REG && cnt_reg == 8'd1) begin
      ack_reg <= 1'b1;
      rdata_reg <= {16'h0000, sd_s_reg};
    end else begin
      ack_reg <= 1'b0;
    end
  end

  assign pio_ack_o = ack_reg;
  assign pio_rdata_o = rdata_reg;
  assign scsi_clk_o = scsi_clk_reg;
  assign dack_n_o = (st_reg != SDBC_XFER);
  assign reg_cs_n_o = (st_reg != SDBC_REG);
  assign reg_rd_n_o = ~((st_reg == SDBC_REG) & ~pio_req_i.wr);
  assign reg_wr_n_o = ~((st_reg == SDBC_REG) & pio_req_i.wr);
  assign reg_addr_o = pio_req_i.addr[5:2];
  assign sd_o = sd_out_reg;
  assign sd_oe_n_o = sd_oe_n_reg;
  assign dma_busy_o = (st_reg == SDBC_XFER) || (st_reg == SDBC_DROP);
endmodule : sdbc_top

/* File: verif/sdbc_properties.sv */
// Port checker for the staging buffer controller.
`timescale 1ns/1ps
module sdbc_properties
  import sdbc_pkg::*;
#(parameter int STROBE_CYC = 16) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire sdbc_pio_req_t pio_req_i,
  input wire logic pio_ack_o,
  input wire logic scsi_clk_o,
  input wire logic dreq_i,
  input wire logic dack_n_o,
  input wire logic reg_cs_n_o,
  input wire logic reg_wr_n_o,
  input wire logic [3:0] reg_addr_o,
  input wire logic sd_oe_n_o,
  input wire logic dma_busy_o
);
  int dk_cnt;
  int cs_cnt;
  wire buf_hit = pio_req_i.sel && !pio_ack_o &&
    pio_req_i.addr[31:17] == 15'h0B8C;
  // Count how long each strobe has been low.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dk_cnt <= 0;
      cs_cnt <= 0;
    end else begin
      dk_cnt <= dack_n_o ? 0 : dk_cnt + 1;
      cs_cnt <= reg_cs_n_o ? 0 : cs_cnt + 1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  ack_pulse_a: assert property (pio_ack_o |=> !pio_ack_o)
    else $error("ack too long");
  buf_ack_a: assert property (buf_hit |=> pio_ack_o)
    else $error("buffer not answered");
  dack_width_a: assert property (
    $rose(dack_n_o) |-> dk_cnt == STROBE_CYC) else $error("dack width");
  win_strobe_a: assert property (
    $rose(reg_cs_n_o) |-> cs_cnt == STROBE_CYC && pio_ack_o)
    else $error("register strobe");
  win_index_a: assert property (
    !reg_cs_n_o && !$past(reg_cs_n_o) |-> $stable(reg_addr_o))
    else $error("register index");
  one_strobe_a: assert property (dack_n_o || reg_cs_n_o)
    else $error("strobes overlap");
  drive_when_a: assert property (
    !sd_oe_n_o |-> !dack_n_o || !reg_wr_n_o) else $error("stray drive");
  busy_dack_a: assert property (!dack_n_o |-> dma_busy_o)
    else $error("busy low in strobe");
  dreq_cause_a: assert property (
    $fell(dack_n_o) |-> $past(dreq_i, 2)) else $error("dack unasked");
  clk_rate_a: assert property ($changed(scsi_clk_o) |=>
    $stable(scsi_clk_o)[*3] ##1 $changed(scsi_clk_o))
    else $error("link clock rate");
  cover property ($rose(dack_n_o));
  cover property ($rose(reg_cs_n_o));
  cover property (buf_hit);
endmodule : sdbc_properties

bind sdbc_top sdbc_properties #(.STROBE_CYC(STROBE_CYC)) u_props (
  .sys_clk_i, .arst_n_i, .pio_req_i, .pio_ack_o, .scsi_clk_o, .dreq_i,
  .dack_n_o, .reg_cs_n_o, .reg_wr_n_o, .reg_addr_o, .sd_oe_n_o,
  .dma_busy_o);

/* File: verif/sdbc_scsi_model.sv */
// Far-side controller model: DMA requests, halfwords and registers.
`timescale 1ns/1ps
module sdbc_scsi_model (
  input wire logic sys_clk_i,
  input wire logic dack_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [3:0] ra_i,
  input wire logic [15:0] sd_i,
  output logic dreq_o = 1'b0,
  output logic [15:0] sd_o = 16'h0000
);
  int left = 0;
  int gap = 0;
  int wt = 0;
  int done = 0;
  logic lo_q = 1'b0;
  logic irq_q = 1'b0;
  logic [15:0] seed = 16'h0000;
  logic [15:0] wval = 16'h0000;
  logic [15:0] got[$];
  // one request per halfword, dropped on acknowledge.
  always @(negedge sys_clk_i) begin
    lo_q <= !dack_n_i;
    if (dack_n_i && lo_q) done <= done + 1;
    // end of the last halfword raises the interrupt.
    if (dack_n_i && lo_q && left == 0) irq_q <= 1'b1;
    if (!dack_n_i && dreq_o) begin
      dreq_o <= 1'b0;
      left <= left - 1;
      got.push_back(sd_i);
      wt <= 0;
    end else if (dack_n_i && !dreq_o && left > 0) begin
      wt <= wt + 1;
      if (wt >= gap) dreq_o <= 1'b1;
    end
    // data held through the strobe, scrambled when idle.
    if (!cs_n_i && !rd_n_i) sd_o <= {12'h5A0, ra_i};
    else if (!dack_n_i || dreq_o) sd_o <= seed + 16'(done);
    else sd_o <= ~sd_o;
    if (!cs_n_i && !wr_n_i) wval <= sd_i;
  end
endmodule : sdbc_scsi_model

/* File: verif/sdbc_tb_top.sv */
// Self-checking bench for the staging buffer controller.
`timescale 1ns/1ps
module sdbc_tb_top;
  import sdbc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  sdbc_pio_req_t req = '0;
  logic ack, dreq, dack_n, cs_n, rd_n, wr_n, oe_n, busy;
  logic [31:0] rdata;
  logic [3:0] ra;
  logic [15:0] sdi, sdo;
  logic [31:0] mem [0:32767];
  logic [31:0] x;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  sdbc_top #(.STROBE_CYC(4)) dut (
    .sys_clk_i, .arst_n_i, .pio_req_i(req), .pio_ack_o(ack),
    .pio_rdata_o(rdata), .scsi_clk_o(), .dreq_i(dreq), .dack_n_o(dack_n),
    .reg_cs_n_o(cs_n), .reg_rd_n_o(rd_n), .reg_wr_n_o(wr_n),
    .reg_addr_o(ra), .sd_i(sdi), .sd_o(sdo), .sd_oe_n_o(oe_n),
    .dma_busy_o(busy));

  // A released data bus shows the inverse of its last value.
  sdbc_scsi_model far (
    .sys_clk_i, .dack_n_i(dack_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .ra_i(ra), .sd_i(oe_n ? ~sdo : sdo), .dreq_o(dreq),
    .sd_o(sdi));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // One processor cycle; shadow copy follows buffer writes by lane.
  task automatic pio(input logic w, input logic [31:0] a,
      input logic [3:0] be, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    req <= '{1'b1, w, a, be, d};
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 99);
    chk({31'h0, ack}, 32'h1);
    // Hold the request through the edge that samples the acknowledge.
    @(negedge sys_clk_i);
    req.sel <= 1'b0;
    for (int b = 0; b < 4; b++)
      if (w && be[b] && a[31:17] == 15'h0B8C) mem[a[16:2]][8*b+:8] = d[8*b+:8];
  endtask : pio

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    pio(1'b0, a, 4'hF, 32'h0);
    chk(rdata, e);
  endtask : rd

  function automatic logic [31:0] wad(input logic [15:0] h, input int k);
    return 32'h1718_0000 | {15'(h[15:1] + 15'(k)), 2'b00};
  endfunction : wad

  // Preload, load the address register, then start the far side.
  task automatic dma(input logic o, input logic [15:0] s, input int n);
    logic [15:0] h;
    int k;
    for (k = 0; k <= n / 2 + 1; k++) pio(1'b1, wad(s, k), 4'hF, $urandom);
    far.got.delete();
    far.seed = 16'($urandom);
    far.done = 0;
    far.gap = n;
    pio(1'b1, 32'h1714_0000, 4'hF, {o, 14'($urandom), s, 1'($urandom)});
    far.irq_q = 1'b0;
    far.left = n;
    k = 0;
    while ((far.irq_q !== 1'b1 || busy !== 1'b0) && k < 999) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k >= 999) begin
      error_cnt++;
      $display("ERROR %0t dma hang", $time);
    end
    chk({31'h0, far.irq_q}, 32'h1);
    repeat (8) @(negedge sys_clk_i);
    chk(32'(far.got.size()), 32'(n));
    for (k = 0; k < n; k++) begin
      h = s + 16'(k);
      if (o) chk({16'h0, far.got[k]}, {16'h0, h[0] ? mem[h[15:1]][31:16]
        : mem[h[15:1]][15:0]});
      else mem[h[15:1]][{h[0], 4'h0}+:16] = far.seed + 16'(k);
    end
    for (k = 0; k <= n / 2 + 1; k++)
      rd(wad(s, k), mem[15'(wad(s, k) >> 2)]);
    $display("dma dir %0b start %h done", o, s);
  endtask : dma

  // Cut a hung run short.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end

  initial begin
    x = $urandom(32'h6AF4);
    repeat (5) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      x = i == 0 ? 32'h1719_FFFC : 32'h1718_0000 | ($urandom & 32'h1FFFC);
      pio(1'b1, x, 4'hF, $urandom);
      pio(1'b1, x, 4'h1 << (i % 4), $urandom);
      rd(x, mem[x[16:2]]);
    end
    rd(32'h1714_0000, 32'h0);
    rd(32'h1720_0000, 32'h0);
    $display("buffer lanes done");
    for (int i = 0; i < 16; i++)
      rd(32'h1710_0000 | (i << 2), {20'h005A0, 4'(i)});
    pio(1'b1, 32'h1710_0008, 4'hF, 32'hABCD_1234);
    chk({16'h0, far.wval}, 32'h1234);
    $display("register window done");
    dma(1'b1, 16'hFFFF, 3);
    dma(1'b0, 16'hFFFE, 4);
    for (int i = 0; i < 4; i++) dma(i[0], 16'($urandom), 2 + i);
    results();
  end
endmodule : sdbc_tb_top
